// file: bench/spi_ctl_port_tb.sv
`timescale 1ns/1ps
module spi_ctl_port_tb;
    import spi_ctl_pkg::*;
    logic       clk, sys_rst, sclk, slave_select_n, mosi, miso, miso_oe, frame_done, write_done;
    int         num_errors, check_count, n_frame, n_write;
    logic [7:0] rd;
    spi_ctl_port spi_ctl_port_i (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
        .slave_select_n(slave_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .frame_done(frame_done), .write_done(write_done));
    spi_host_model spi_host_model_i (.sclk(sclk), .slave_select_n(slave_select_n),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
    initial clk = 1'b0;
    always #10 clk = ~clk;
    // pulse totals let each frame be judged after it ends
    always @(posedge clk) begin
        if (frame_done === 1'b1) n_frame++;
        if (write_done === 1'b1) n_write++;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // every frame runs at the bench link clock; read data must keep up with it
    task automatic frame(input logic [6:0] a, input logic rw, input logic [7:0] d,
                         input int extra, output logic [7:0] r);
        int f0, w0;
        f0 = n_frame;
        w0 = n_write;
        spi_host_model_i.xfer({a, rw}, d, 80, extra, r);
        check(8'(n_frame - f0), 8'h01);
        check(8'(n_write - w0), (rw == DIR_WRITE) ? 8'h01 : 8'h00);
    endtask
    task automatic test_reset;
        check({4'h0, miso, miso_oe, frame_done, write_done}, 8'h00);
        frame(7'h7F, DIR_READ, 8'hFF, 0, rd);
        check(rd, REG_RESET);
        $display("test_reset done");
    endtask
    // distinct data at edge and one-hot addresses catches address slips
    task automatic test_write_read;
        // a lone top bit catches a read value that is fetched twice
        logic [6:0] a [5] = '{7'h00, 7'h7F, 7'h01, 7'h40, 7'h20};
        logic [7:0] d [5] = '{8'hA5, 8'h5A, 8'h81, 8'h3C, 8'h80};
        for (int i = 0; i < 5; i++) frame(a[i], DIR_WRITE, d[i], 0, rd);
        for (int i = 0; i < 5; i++) begin
            frame(a[i], DIR_READ, 8'h00, 0, rd);
            check(rd, d[i]);
        end
        $display("test_write_read done");
    endtask
    task automatic test_read_no_write;
        frame(7'h40, DIR_READ, 8'hFF, 0, rd);
        check(rd, 8'h3C);
        frame(7'h40, DIR_READ, 8'h00, 0, rd);
        check(rd, 8'h3C);
        $display("test_read_no_write done");
    endtask
    // bits past sixteen with select still low must not start a new command
    task automatic test_extra_bits;
        frame(7'h01, DIR_WRITE, 8'hC3, 16, rd);
        frame(7'h01, DIR_READ, 8'h00, 0, rd);
        check(rd, 8'hC3);
        check(8'(spi_host_model_i.oe_bad), 8'h00);
        check({7'h00, miso_oe}, 8'h00);
        $display("test_extra_bits done");
    endtask
    initial begin
        sys_rst = 1'b1;
        num_errors = 0;
        check_count = 0;
        n_frame = 0;
        n_write = 0;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        test_reset();
        test_write_read();
        test_read_no_write();
        test_extra_bits();
        print_verdict();
    end
    // hang guard
    initial begin
        #1_000_000;
        num_errors++;
        print_verdict();
    end
endmodule // spi_ctl_port_tb

// file: bench/spi_host_model.sv
`timescale 1ns/1ps
// host side master: makes the link clock, frames every transfer
module spi_host_model (
    // serial link pins
    output logic      sclk,
    output logic      slave_select_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    // the protocol strap stays high all run; this port only exists in serial mode
    localparam logic SERIAL_STRAP = 1'b1;
    int oe_bad;
    initial begin
        sclk = 1'b0;
        slave_select_n = 1'b1;
        mosi = 1'b1;
        oe_bad = 0;
    end
    // link clock stands still low outside frames; extra clocks keep select low
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, input int half,
                        input int extra, output logic [7:0] rdat);
        logic [15:0] sh;
        sh = {cmd, wdat};
        rdat = 8'h00;
        slave_select_n = 1'b0;
        #(half);
        for (int i = 0; i < 16 + extra; i++) begin
            sclk = 1'b1;
            mosi = sh[15];
            sh = {sh[14:0], ~sh[15]};
            #(half);
            sclk = 1'b0;
            if (i >= 8 && i < 16) rdat = {rdat[6:0], miso};
            if (miso_oe !== 1'b1) oe_bad++;
            #(half);
        end
        #(half * 4);
        slave_select_n = 1'b1;
        mosi = ~mosi;  // released line must not show a stale bit
        #(half);
    endtask
endmodule // spi_host_model

// file: core/ctl_reg_mem.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// control register storage, registered read data
// ------------------------------------------------------------
module ctl_reg_mem #(
    parameter int DEPTH = spi_ctl_pkg::REG_COUNT
) (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  sys_rst,
    // access port
    reg_bus_if.store   bus
);
    import spi_ctl_pkg::*;

    logic [7:0] mem      [DEPTH];
    logic [7:0] next_mem [DEPTH];
    logic [7:0] rd_q;

    // write decode
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            next_mem[i] = mem[i];
        end
        if (bus.wr_en) begin
            next_mem[bus.wr_addr] = bus.wr_data;
        end
    end

    // storage clears to defaults on reset
    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= sys_rst ? REG_RESET : next_mem[i];
        end
        rd_q <= sys_rst ? REG_RESET : mem[bus.rd_addr];
    end

    assign bus.rd_data = rd_q;
endmodule // ctl_reg_mem

// file: core/reg_bus_if.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// register file access between frame engine and storage
// ------------------------------------------------------------
interface reg_bus_if;
    logic       wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;

    modport engine (output wr_en, output wr_addr, output wr_data, output rd_addr,
                    input rd_data);
    modport store  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                    output rd_data);
endinterface

// file: core/spi_ctl_pkg.sv
package spi_ctl_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int          BYTE_BITS  = 8;
    localparam int          ADDR_BITS  = 7;
    localparam int          REG_COUNT  = 128;
    localparam logic [3:0]  LAST_BIT   = 4'h7;
    localparam logic        DIR_WRITE  = 1'b0;
    localparam logic        DIR_READ   = 1'b1;
    localparam logic [7:0]  REG_RESET  = 8'h00;

    typedef enum logic [1:0] {
        FR_IDLE,
        FR_CMD,
        FR_DATA,
        FR_DONE
    } frame_e;
endpackage

// file: core/spi_ctl_port.sv
`timescale 1ns/1ps
module spi_ctl_port (
    // system
    input  wire logic clk,
    input  wire logic sys_rst,
    // serial link pins
    input  wire logic sclk,
    input  wire logic slave_select_n,
    input  wire logic mosi,
    output logic      miso,
    output logic      miso_oe,
    // status
    output logic      frame_done,
    output logic      write_done
);
    import spi_ctl_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_s, ss_s, mosi_s;
    logic       sclk_d, ss_d;
    // two flops per pin; the third stage only feeds edge finding
    always_ff @(posedge clk) begin
        sclk_s <= sys_rst ? 2'h0 : {sclk_s[0], sclk};
        ss_s   <= sys_rst ? 2'h3 : {ss_s[0], slave_select_n};
        mosi_s <= sys_rst ? 2'h0 : {mosi_s[0], mosi};
        sclk_d <= sys_rst ? 1'b0 : sclk_s[1];
        ss_d   <= sys_rst ? 1'b1 : ss_s[1];
    end

    // with clock idle low, rising edge is first edge (launch), falling samples
    logic lead_edge, trail_edge, ss_fall, ss_act;
    assign lead_edge  = sclk_s[1] & ~sclk_d;
    assign trail_edge = ~sclk_s[1] & sclk_d;
    assign ss_fall    = ~ss_s[1] & ss_d;
    assign ss_act     = ~ss_s[1];

    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    reg_bus_if rb ();
    ctl_reg_mem #(.DEPTH(REG_COUNT)) ctl_reg_mem_i (.clk(clk), .sys_rst(sys_rst), .bus(rb));

    frame_e     st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shin, next_shin;
    logic [7:0] shout, next_shout;
    logic [6:0] addr, next_addr;
    logic       is_rd, next_is_rd;
    logic       load_pend, next_load_pend;
    // second stage waits out the registered read of the storage
    logic       load_go, next_load_go;
    logic       next_miso, next_oe, next_fdone, next_wdone;
    logic       wr_en, next_wr_en;
    logic [7:0] wr_data, next_wr_data;

    assign rb.wr_en   = wr_en;
    assign rb.wr_addr = addr;
    assign rb.wr_data = wr_data;
    assign rb.rd_addr = addr;

    // next-state logic; device never starts a frame on its own
    always_comb begin
        next_st        = st;
        next_cnt       = cnt;
        next_shin      = shin;
        next_shout     = shout;
        next_addr      = addr;
        next_is_rd     = is_rd;
        next_load_pend = 1'b0;
        next_load_go   = load_pend;
        next_miso      = miso;
        next_oe        = miso_oe;
        next_fdone     = 1'b0;
        next_wdone     = 1'b0;
        next_wr_en     = 1'b0;
        next_wr_data   = wr_data;
        // read data stands two cycles after the command boundary; loaded once only,
        // so a value whose shifted remainder is zero is never fetched again
        if (load_go) begin
            next_shout = rb.rd_data;
        end
        if (ss_fall) begin
            next_st    = FR_CMD;
            next_cnt   = 4'h0;
            next_shout = REG_RESET;
            next_oe    = 1'b1;
        end else if (!ss_act) begin
            next_oe = 1'b0;
            next_st = FR_IDLE;
        end else begin
            unique case (st)
                FR_IDLE, FR_DONE: begin
                end
                FR_CMD: begin
                    if (lead_edge) begin
                        next_miso = shout[BYTE_BITS-1];
                        next_shout = {shout[6:0], 1'b0};
                    end
                    if (trail_edge) begin
                        next_shin = {shin[6:0], mosi_s[1]};
                        next_cnt  = cnt + 4'h1;
                        if (cnt == LAST_BIT) begin
                            next_addr  = shin[6:0];
                            next_is_rd = mosi_s[1];
                            next_cnt   = 4'h0;
                            next_st    = FR_DATA;
                        end
                    end
                    // fetch read value at the command boundary
                    if (st == FR_CMD && trail_edge && cnt == LAST_BIT) begin
                        next_load_pend = (mosi_s[1] == DIR_READ);
                    end
                end
                FR_DATA: begin
                    // value to send was loaded before the first data clock rises
                    if (lead_edge) begin
                        next_miso  = is_rd ? shout[BYTE_BITS-1] : 1'b0;
                        next_shout = {shout[6:0], 1'b0};
                    end
                    if (trail_edge) begin
                        next_shin = {shin[6:0], mosi_s[1]};
                        next_cnt  = cnt + 4'h1;
                        if (cnt == LAST_BIT) begin
                            next_st      = FR_DONE;
                            next_fdone   = 1'b1;
                            next_wr_en   = (is_rd == DIR_WRITE);
                            next_wdone   = (is_rd == DIR_WRITE);
                            next_wr_data = {shin[6:0], mosi_s[1]};
                        end
                    end
                end
                default: next_st = FR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st        <= FR_IDLE;
            cnt       <= 4'h0;
            shin      <= 8'h00;
            shout     <= 8'h00;
            addr      <= 7'h00;
            is_rd     <= 1'b0;
            load_pend <= 1'b0;
            load_go   <= 1'b0;
            miso      <= 1'b0;
            miso_oe   <= 1'b0;
            frame_done <= 1'b0;
            write_done <= 1'b0;
            wr_en     <= 1'b0;
            wr_data   <= 8'h00;
        end else begin
            st        <= next_st;
            cnt       <= next_cnt;
            shin      <= next_shin;
            shout     <= next_shout;
            addr      <= next_addr;
            is_rd     <= next_is_rd;
            load_pend <= next_load_pend;
            load_go   <= next_load_go;
            miso      <= next_miso;
            miso_oe   <= next_oe;
            frame_done <= next_fdone;
            write_done <= next_wdone;
            wr_en     <= next_wr_en;
            wr_data   <= next_wr_data;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_WRITE_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
        wr_en |-> (is_rd == DIR_WRITE)) else $error("store on read frame");
    AST_NEW_FRAME: assert property (@(posedge clk) disable iff (sys_rst)
        ss_fall |=> (st == FR_CMD && cnt == 4'h0)) else $error("frame not restarted");
    AST_OE_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        (!ss_act && !ss_fall) |=> !miso_oe) else $error("miso driven while idle");
    AST_DONE_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
        frame_done |=> !frame_done) else $error("done not a pulse");
    AST_WDONE: assert property (@(posedge clk) disable iff (sys_rst)
        write_done |-> frame_done) else $error("write without frame end");
    AST_CMD_LEN: assert property (@(posedge clk) disable iff (sys_rst)
        (st == FR_CMD) |-> cnt <= LAST_BIT) else $error("command overrun");
    AST_WR_DATA: assert property (@(posedge clk) disable iff (sys_rst)
        wr_en |-> wr_data == shin) else $error("write data mismatch");
    AST_READ_DIR: assert property (@(posedge clk) disable iff (sys_rst)
        (st == FR_DATA && is_rd && lead_edge) |=> miso == $past(shout[7]))
        else $error("read bit wrong");

    // pin and engine-state checks; each holds for any host that keeps the clock rules
    AST_OE_ACTIVE: assert property (@(posedge clk) disable iff (sys_rst)
        ss_act |=> miso_oe) else $error("miso not driven in frame");
    AST_IDLE_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        !ss_act |=> (st == FR_IDLE)) else $error("engine busy without select");
    AST_CMD_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
        (st == FR_CMD && ss_act && lead_edge) |=> !miso) else $error("miso active in command");
    AST_WRITE_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
        (st == FR_DATA && !is_rd && ss_act && lead_edge) |=> !miso)
        else $error("miso active in write data");
    AST_LOAD_READ: assert property (@(posedge clk) disable iff (sys_rst)
        load_go |-> is_rd) else $error("read value fetched on a write");
    AST_DONE_AFTER: assert property (@(posedge clk) disable iff (sys_rst)
        (st == FR_DATA && ss_act && trail_edge && cnt == LAST_BIT) |=> frame_done)
        else $error("frame end missed");
endmodule // spi_ctl_port
